// *** pkg/hwt_pkg.sv ***
// hibernation wake timer: register map, field layout, reset values, timing
// assumes one 250 MHz core clock; the 32.768 kHz time base is derived by a rate divider
package hwt_pkg;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned CNT_W          = 16;

    localparam logic [7:0]  OFF_PRELOAD    = 8'h00;
    localparam logic [7:0]  OFF_CONTROL    = 8'h04;
    localparam logic [7:0]  OFF_COUNT      = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STATUS = 8'h0c;
    localparam logic [7:0]  OFF_IRQ_MASK   = 8'h10;

    localparam int unsigned CTRL_RES_BIT   = 0;
    localparam int unsigned IRQ_EXPIRE_BIT = 0;

    localparam logic [15:0] PRELOAD_RST    = 16'h0000;
    localparam logic [15:0] COUNT_RST      = 16'h0000;
    localparam logic        CTRL_RES_RST   = 1'b0;
    localparam logic        IRQ_MASK_RST   = 1'b0;

    // core clock and slow time base, in hertz
    localparam longint unsigned CORE_HZ    = 64'd250000000;
    localparam longint unsigned SLOW_HZ    = 64'd32768;
    // core cycles per slow tick, rounded down (about 30.5 us)
    localparam int unsigned SLOW_DIV       = int'(CORE_HZ / SLOW_HZ);
    // slow ticks per coarse step: 0.125 s at 32768 Hz
    localparam int unsigned COARSE_MS      = 125;
    localparam int unsigned COARSE_TICKS   = int'((SLOW_HZ * COARSE_MS) / 64'd1000);
    // cycles the clock request stays high after an access
    localparam int unsigned CLKREQ_HOLD    = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } hwt_bus_req_t;
endpackage

// *** core/hwt_tick_div.sv ***
// hwt_tick_div: free-running divider giving a one-cycle pulse every DIV enabled cycles
// assumes same clock and reset as its parent
module hwt_tick_div #(
    parameter int unsigned DIV = 8
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic step,
    output logic      tick
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
        end else if (ce && step) begin
            cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + W'(1);
        end
    end

    assign tick = ce && step && (cnt_reg == LAST);
endmodule

// *** core/hwt_timer.sv ***
// hwt_timer: 16-bit hibernation wake down-counter with register port and interrupt
// assumes a single-cycle register master on core_clk; no bus wait states
//
// Functional notes
// - counter is sixteen bits wide and counts down toward zero
// - two resolutions: fine up to about 2 s, coarse 0.125 s up to 136.5 min
// - nonzero preload write loads counter and starts counting down from it
// - reaching zero while enabled pulses the event output and raises interrupt
// - expiry event is usable as a wake source during hibernation
// - counting derives from the 32 kHz time base through a prescaler
// - counting runs on the slow base divided from core_clk; it halts when core_clk stops or ce is low
// - sleep enable inputs are ignored and never affect counting
// - clock request asserted only around register accesses, briefly
// - system reset returns all register-map fields to defaults; the prescaler dividers keep running
// - preload at 00h, control at 04h, count at 08h
// - writing zero to preload disables counter; no decrements, no events
// - control bit set gives 0.125 s per count, clear gives 30.5 us
// - count register reads live counter value and ignores writes
module hwt_timer #(
    parameter int unsigned SLOW_DIV     = hwt_pkg::SLOW_DIV,
    parameter int unsigned COARSE_TICKS = hwt_pkg::COARSE_TICKS
) (
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    input  wire logic                       system_reset_in,
    input  wire logic [hwt_pkg::ADDR_W-1:0] addr,
    input  wire logic [hwt_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [hwt_pkg::DATA_W-1:0] rdata,
    input  wire logic                       sleep_en,
    output logic                            clk_req,
    output logic                            wake_count_event,
    output logic                            wake_out,
    output logic                            irq
);
    hwt_pkg::hwt_bus_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // reset pin comes from outside: two-stage synchroniser
    logic srst_meta_reg;
    logic srst_reg;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            srst_meta_reg <= 1'b0;
            srst_reg      <= 1'b0;
        end else if (ce) begin
            srst_meta_reg <= system_reset_in;
            srst_reg      <= srst_meta_reg;
        end
    end

    // sleep_en deliberately unused: counting never stops for sleep
    logic unused_sleep;
    assign unused_sleep = sleep_en;

    logic [hwt_pkg::CNT_W-1:0] countdown_load_value_reg;
    logic [hwt_pkg::CNT_W-1:0] countdown_value_reg;
    logic                      run_reg;
    logic                      res_coarse_reg;
    logic                      irq_status_reg;
    logic                      irq_mask_reg;

    logic wr_preload;
    logic wr_control;
    logic wr_mask;
    logic rd_status;
    assign wr_preload = ce && req.wr && (req.addr == hwt_pkg::OFF_PRELOAD);
    assign wr_control = ce && req.wr && (req.addr == hwt_pkg::OFF_CONTROL);
    assign wr_mask    = ce && req.wr && (req.addr == hwt_pkg::OFF_IRQ_MASK);
    assign rd_status  = ce && req.rd && (req.addr == hwt_pkg::OFF_IRQ_STATUS);

    // slow base then coarse prescaler
    logic slow_tick;
    logic coarse_tick;
    logic step;
    hwt_tick_div #(.DIV(SLOW_DIV)) u_slow (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .step     (1'b1),
        .tick     (slow_tick)
    );
    hwt_tick_div #(.DIV(COARSE_TICKS)) u_coarse (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .step     (slow_tick),
        .tick     (coarse_tick)
    );
    assign step = res_coarse_reg ? coarse_tick : slow_tick;

    logic expire;
    assign expire = run_reg && step && (countdown_value_reg == hwt_pkg::CNT_W'(1)) && !srst_reg
                    && !wr_preload;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            countdown_load_value_reg <= hwt_pkg::PRELOAD_RST;
        end else if (ce) begin
            if (srst_reg) begin
                countdown_load_value_reg <= hwt_pkg::PRELOAD_RST;
            end else if (wr_preload) begin
                countdown_load_value_reg <= req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            countdown_value_reg <= hwt_pkg::COUNT_RST;
            run_reg             <= 1'b0;
        end else if (ce) begin
            if (srst_reg) begin
                countdown_value_reg <= hwt_pkg::COUNT_RST;
                run_reg             <= 1'b0;
            end else if (wr_preload) begin
                countdown_value_reg <= req.wdata;
                run_reg             <= (req.wdata != '0);
            end else if (run_reg && step) begin
                countdown_value_reg <= countdown_value_reg - hwt_pkg::CNT_W'(1);
                if (countdown_value_reg == hwt_pkg::CNT_W'(1)) begin
                    run_reg <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            res_coarse_reg <= hwt_pkg::CTRL_RES_RST;
            irq_mask_reg   <= hwt_pkg::IRQ_MASK_RST;
        end else if (ce) begin
            if (srst_reg) begin
                res_coarse_reg <= hwt_pkg::CTRL_RES_RST;
                irq_mask_reg   <= hwt_pkg::IRQ_MASK_RST;
            end else begin
                if (wr_control) begin
                    res_coarse_reg <= req.wdata[hwt_pkg::CTRL_RES_BIT];
                end
                if (wr_mask) begin
                    irq_mask_reg <= req.wdata[hwt_pkg::IRQ_EXPIRE_BIT];
                end
            end
        end
    end

    // sticky status: a set in the same cycle as the read-clear wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status_reg <= 1'b0;
        end else if (ce) begin
            if (srst_reg) begin
                irq_status_reg <= 1'b0;
            end else if (expire) begin
                irq_status_reg <= 1'b1;
            end else if (rd_status) begin
                irq_status_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wake_count_event <= 1'b0;
        end else if (ce) begin
            wake_count_event <= expire;
        end
    end

    assign wake_out = wake_count_event;
    assign irq      = irq_status_reg && irq_mask_reg;

    // read data, one cycle after the strobe; count reads live value
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (req.rd) begin
                unique case (req.addr)
                    hwt_pkg::OFF_PRELOAD:    rdata <= countdown_load_value_reg;
                    hwt_pkg::OFF_CONTROL:    rdata <= {15'h0000, res_coarse_reg};
                    hwt_pkg::OFF_COUNT:      rdata <= countdown_value_reg;
                    hwt_pkg::OFF_IRQ_STATUS: rdata <= {15'h0000, irq_status_reg};
                    hwt_pkg::OFF_IRQ_MASK:   rdata <= {15'h0000, irq_mask_reg};
                    default:                 rdata <= '0;
                endcase
            end
        end
    end

    // clock request: raised by any access, held briefly to move updates in
    logic [1:0] clkreq_cnt_reg;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            clkreq_cnt_reg <= '0;
        end else if (ce) begin
            if (req.wr || req.rd) begin
                clkreq_cnt_reg <= 2'(hwt_pkg::CLKREQ_HOLD);
            end else if (clkreq_cnt_reg != '0) begin
                clkreq_cnt_reg <= clkreq_cnt_reg - 2'h1;
            end
        end
    end
    assign clk_req = (req.wr || req.rd) || (clkreq_cnt_reg != '0);
endmodule

// *** dv/hwt_timer_assertions.sv ***
// hwt_timer checker: event pulses, clock request window, read data timing
// assumes bind onto hwt_timer with ce held high by the bench
module hwt_timer_assertions #(
    parameter int unsigned SLOW_DIV     = 4,
    parameter int unsigned COARSE_TICKS = 3
) (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        ce,
    input wire logic        system_reset_in,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        sleep_en,
    input wire logic        clk_req,
    input wire logic        wake_count_event,
    input wire logic        wake_out,
    input wire logic        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence pre_wr_rd_s;
        wr && addr == hwt_pkg::OFF_PRELOAD ##1 rd && addr == hwt_pkg::OFF_PRELOAD;
    endsequence
    sequence sys_rst_s;
        system_reset_in [*3];
    endsequence
    wake_pulse_a: assert property (wake_count_event |=> !wake_count_event)
        else $error("wake event longer than one cycle");
    wake_same_a: assert property (wake_out == wake_count_event)
        else $error("wake output differs from event");
    clkreq_hold_a: assert property ((wr || rd) && ce |-> clk_req ##1 clk_req ##1 clk_req)
        else $error("clock request dropped early");
    clkreq_idle_a: assert property (!(wr || rd) && !$past(wr || rd) && !$past(wr || rd, 2)
        |-> !clk_req)
        else $error("clock request without access");
    rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside read answer");
    preload_back_a: assert property (pre_wr_rd_s |=> rdata == $past(wdata, 2))
        else $error("preload readback wrong");
    irq_cause_a: assert property ($rose(irq) |-> wake_count_event
        || $past(wr && addr == hwt_pkg::OFF_IRQ_MASK))
        else $error("interrupt without expiry");
    irq_clear_a: assert property (rd && addr == hwt_pkg::OFF_IRQ_STATUS |=> !irq || wake_count_event)
        else $error("interrupt not cleared by status read");
    sys_reset_a: assert property (sys_rst_s |=> !irq && !wake_count_event)
        else $error("system reset left interrupt");
endmodule

bind hwt_timer hwt_timer_assertions #(.SLOW_DIV(SLOW_DIV), .COARSE_TICKS(COARSE_TICKS))
    hwt_timer_assertions_i (.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .system_reset_in(system_reset_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sleep_en(sleep_en), .clk_req(clk_req),
    .wake_count_event(wake_count_event), .wake_out(wake_out), .irq(irq));

// *** dv/hwt_timer_tb.sv ***
// hwt_timer_tb: self-checking bench driving the register port and timing expiry
// assumes shortened dividers; reads queue expected ranges for the monitor
module hwt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DIV = 4;
    localparam int CT  = 3;
    logic        core_clk, nrst, ce, system_reset_in, wr, rd, sleep_en, rd_q;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata;
    logic        clk_req, wake_count_event, wake_out, irq;
    logic [31:0] rng, e_m;
    logic [31:0] exp_q[$];
    int          fail_count, compares, n_ev, n0;
    hwt_timer #(.SLOW_DIV(DIV), .COARSE_TICKS(CT)) hwt_timer_i (.core_clk(core_clk),
        .nrst(nrst), .ce(ce), .system_reset_in(system_reset_in), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep_en(sleep_en),
        .clk_req(clk_req), .wake_count_event(wake_count_event), .wake_out(wake_out), .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic final_report;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
        compares++;
        if (((v >= lo) && (v <= hi)) !== 1'b1) begin
            fail_count++;
            $display("Error %0t: got %0h want %0h..%0h", $time, v, lo, hi);
        end
    endtask
    // one bus cycle; strobes stay up until idle so back-to-back needs no gap
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d = 16'h0000,
                       input logic [15:0] lo = 16'h0000, input logic [15:0] hi = 16'h0000);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        if (!w) exp_q.push_back({lo, hi});
        @(posedge core_clk);
    endtask
    task automatic idle;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge core_clk);
    endtask
    // irq is combinational from registers: look mid-cycle, then realign to the edge
    task automatic chk_irq(input logic v);
        @(negedge core_clk);
        chk(32'(irq), 32'(v), 32'(v));
        @(posedge core_clk);
    endtask
    task automatic wait_ev(input int lo, input int hi);
        int c, e;
        e = n_ev;
        c = 0;
        while (n_ev == e && c < hi + 4) begin
            @(posedge core_clk);
            c++;
        end
        if (n_ev == e) begin
            fail_count++;
            $display("Error %0t: no wake event within %0d cycles", $time, c);
            final_report();
        end else begin
            chk(32'(c), 32'(lo), 32'(hi));
        end
    endtask
    task automatic run(input logic [15:0] n, input int st);
        rng = xs(rng);
        sleep_en <= rng[0];
        bus(1'b1, hwt_pkg::OFF_PRELOAD, n);
        idle();
        wait_ev((int'(n) - 1) * st, int'(n) * st + 3);
    endtask
    // monitor: the answer to a read stands in the cycle after its strobe
    always @(posedge core_clk) begin
        rd_q <= rd;
        if (wake_count_event === 1'b1) n_ev <= n_ev + 1;
        if (rd_q === 1'b1) begin
            e_m = exp_q.pop_front();
            chk(32'(rdata), 32'(e_m[31:16]), 32'(e_m[15:0]));
        end
    end
    initial begin
        {nrst, system_reset_in, wr, rd, sleep_en} = 5'h00;
        {addr, wdata} = 24'h000000;
        ce = 1'b1;
        rng = 32'hdd99;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a <= 20; a += 4) bus(1'b0, 8'(a));
        bus(1'b1, hwt_pkg::OFF_COUNT, 16'hffff);
        bus(1'b1, hwt_pkg::OFF_PRELOAD, 16'h0003);
        bus(1'b0, hwt_pkg::OFF_PRELOAD, 16'h0000, 16'h0003, 16'h0003);
        bus(1'b0, hwt_pkg::OFF_COUNT, 16'h0000, 16'h0002, 16'h0003);
        idle();
        wait_ev(2 * DIV, 3 * DIV - 1);
        bus(1'b0, hwt_pkg::OFF_COUNT);
        bus(1'b0, hwt_pkg::OFF_IRQ_STATUS, 16'h0000, 16'h0001, 16'h0001);
        bus(1'b0, hwt_pkg::OFF_IRQ_STATUS);
        idle();
        chk_irq(1'b0);
        bus(1'b1, hwt_pkg::OFF_IRQ_MASK, 16'h0001);
        run(16'h0002, DIV);
        chk_irq(1'b1);
        bus(1'b0, hwt_pkg::OFF_IRQ_STATUS, 16'h0000, 16'h0001, 16'h0001);
        bus(1'b1, hwt_pkg::OFF_CONTROL, 16'h0001);
        bus(1'b0, hwt_pkg::OFF_CONTROL, 16'h0000, 16'h0001, 16'h0001);
        idle();
        chk_irq(1'b0);
        run(16'h0002, DIV * CT);
        bus(1'b1, hwt_pkg::OFF_CONTROL, 16'h0000);
        repeat (4) run({13'h0000, rng[3:1]} | 16'h0001, DIV);
        bus(1'b1, hwt_pkg::OFF_PRELOAD, 16'h0006);
        bus(1'b1, hwt_pkg::OFF_PRELOAD, 16'h0000);
        idle();
        n0 = n_ev;
        repeat (40) @(posedge core_clk);
        chk(32'(n_ev - n0), 0, 0);
        bus(1'b1, hwt_pkg::OFF_PRELOAD, 16'h0007);
        bus(1'b1, hwt_pkg::OFF_CONTROL, 16'h0001);
        idle();
        system_reset_in <= 1'b1;
        repeat (3) @(posedge core_clk);
        system_reset_in <= 1'b0;
        repeat (2) @(posedge core_clk);
        for (int a = 0; a <= 16; a += 4) bus(1'b0, 8'(a));
        idle();
        repeat (3) @(posedge core_clk);
        final_report();
    end
endmodule
